//--- core/uef_core.sv
// Enhanced flow-control logic of one UART channel with FIFO ready status
// What this block does
// - Upper select bits pick transmit flow pairs
// - Lower select bits pick receive compare pairs
// - Dual mode treats two characters as sequence
// - Enhanced bit set allows and restores guarded bits
// - Enhanced bit clear saves and hides guarded bits
// - Guarded bits read zero after reset
// - Special detect stores match, sets source bit4
// - Character bit0 compares with received LSB
// - Auto request raises interrupt, stops at next level
// - Auto request resumes below trigger level
// - Without auto, request follows modem control bit
// - Auto clear-to-send high stops transmitting
// - Each channel has 64-byte FIFOs
// - Ready bits 0-3 show transmit FIFO space
// - Ready bits 4-7 show receive below trigger and no timeout
// - Reset clears control regs, source reads 01
// - Line status resets to 60 hex
// - Reset clears modem deltas, keeps live bits
// - Reset drives pins high, transmit ready low
// - Enhanced control reachable only with latch bit
`timescale 1ns/1ps
module uef_core import uef_pkg::*; #(
	parameter int NUM_CH = 4,
	parameter int FIFO_DEPTH = 64
) (
	// Clock, reset, enable
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Register port
	input wire uef_bus_t reg_bus_i,
	output logic [7:0] rd_data_o,
	// Receive and transmit character paths
	input wire uef_char_t rx_char_i,
	output uef_char_t rx_store_o,
	output uef_char_t tx_flow_o,
	input wire logic tx_flow_ready_i,
	output logic tx_enable_o,
	output logic rx_trig_o,
	// FIFO levels of all channels, channel 0 is this one
	input wire logic [NUM_CH-1:0][LVL_W-1:0] rx_lvl_i,
	input wire logic [NUM_CH-1:0][LVL_W-1:0] tx_lvl_i,
	input wire logic [NUM_CH-1:0] rx_tout_i,
	input wire logic [NUM_CH-1:0][1:0] ch_trig_i,
	input wire logic [7:0] line_stat_i,
	// Modem and serial pins
	input wire logic cts_n_i,
	input wire logic dsr_n_i,
	input wire logic ri_n_i,
	input wire logic cd_n_i,
	input wire logic ser_data_i,
	output logic ser_tx_o,
	output logic rts_n_o,
	output logic dtr_n_o,
	output logic receive_ready_pin_n_o,
	output logic transmit_ready_pin_n_o
);
	localparam logic [LVL_W-1:0] DEPTH_L = LVL_W'(FIFO_DEPTH);

	uef_state_t s_r;
	uef_state_t s_nxt;
	logic [7:0] efc;
	logic enh;
	logic dlab;
	logic [7:0] ien_vis;
	logic [7:0] fctl_vis;
	logic [7:0] mctl_vis;
	logic [7:0] src_vis;
	logic [7:0] mstat_vis;
	logic [7:0] frdy;
	logic [3:0] mdm_n;
	logic [3:0] mdm_hi;
	logic [3:0] mdm_chg;
	logic [LVL_W-1:0] own_lvl;
	logic [LVL_W-1:0] trig;
	logic [LVL_W-1:0] trig_next;
	logic want_pause;
	logic [NUM_CH-1:0] frdy_tx;
	logic [NUM_CH-1:0] frdy_rx;

	assign efc = s_r.enhanced_feature_control;
	assign enh = efc[ENH_ON];
	assign dlab = s_r.line_control_reg[LC_DLAB];
	assign own_lvl = rx_lvl_i[0];
	assign trig = trig_lvl(s_r.fifo_control_reg[7:6]);
	assign trig_next = (s_r.fifo_control_reg[7:6] == 2'b11) ? DEPTH_L
		: trig_lvl(s_r.fifo_control_reg[7:6] + 2'b01);
	assign want_pause = own_lvl >= trig;

	// Guarded bits are stored but hidden while the enhanced bit is off
	assign ien_vis = enh ? s_r.interrupt_enable_reg
		: s_r.interrupt_enable_reg & ~GUARD_INT_EN;
	assign fctl_vis = enh ? s_r.fifo_control_reg
		: s_r.fifo_control_reg & ~GUARD_FCTL;
	assign mctl_vis = enh ? s_r.modem_control_reg
		: s_r.modem_control_reg & ~GUARD_MDM;
	assign src_vis = {2'b00, enh ? {s_r.rts_stop, s_r.sc_hit} : 2'b00,
		3'b000, ~s_r.sc_hit};

	assign mdm_n = {cd_n_i, ri_n_i, dsr_n_i, cts_n_i};
	assign mdm_hi = s_r.modem_control_reg[MC_LOOP]
		? {s_r.modem_control_reg[3:2], s_r.modem_control_reg[MC_DTR],
		s_r.modem_control_reg[MC_RTS]} : ~mdm_n;
	assign mdm_chg = {s_r.mdm_prev[3] ^ mdm_n[3], ~s_r.mdm_prev[2] & mdm_n[2],
		s_r.mdm_prev[1:0] ^ mdm_n[1:0]} & {4{s_r.prev_ok}};
	assign mstat_vis = {mdm_hi, s_r.mdm_delta};

	genvar g;
	for (g = 0; g < NUM_CH; g++) begin : g_frdy
		logic [1:0] tsel;
		assign tsel = (g == 0) ? s_r.fifo_control_reg[7:6] : ch_trig_i[g];
		assign frdy_tx[g] = tx_lvl_i[g] != DEPTH_L;
		assign frdy_rx[g] = (rx_lvl_i[g] < trig_lvl(tsel)) & ~rx_tout_i[g];
	end
	assign frdy = 8'({frdy_rx, frdy_tx});

	always_comb begin
		logic [7:0] d;
		logic [7:0] rd;
		logic cons;
		logic [7:0] pa;
		logic [7:0] re;
		d = rx_char_i.data;
		rd = 8'h00;
		cons = 1'b0;
		pa = 8'h00;
		re = 8'h00;
		s_nxt = s_r;
		if (ce_i) begin
			// Read mux and read side effects
			if (reg_bus_i.rd) begin
				if (dlab && reg_bus_i.addr == ADR_ENH) begin
					rd = efc;
				end else if (dlab && reg_bus_i.addr == ADR_RES1) begin
					rd = s_r.resume_char_first;
				end else if (dlab && reg_bus_i.addr == ADR_RES2) begin
					rd = s_r.resume_char_second;
				end else if (dlab && reg_bus_i.addr == ADR_PAU1) begin
					rd = s_r.pause_char_first;
				end else if (dlab && reg_bus_i.addr == ADR_PAU2) begin
					rd = s_r.pause_char_second;
				end else if (reg_bus_i.addr == ADR_LINE_CTL) begin
					rd = s_r.line_control_reg;
				end else if (reg_bus_i.addr == ADR_FIFO_RDY) begin
					rd = frdy;
				end else if (!dlab && reg_bus_i.addr == ADR_INT_EN) begin
					rd = ien_vis;
				end else if (!dlab && reg_bus_i.addr == ADR_FCTL) begin
					rd = src_vis;
					s_nxt.sc_hit = 1'b0;
				end else if (!dlab && reg_bus_i.addr == ADR_MDM_CTL) begin
					rd = mctl_vis;
				end else if (!dlab && reg_bus_i.addr == ADR_LINE_STAT) begin
					rd = s_r.line_status_reg;
				end else if (!dlab && reg_bus_i.addr == ADR_MDM_STAT) begin
					rd = mstat_vis;
					s_nxt.mdm_delta = 4'h0;
				end else if (!dlab && reg_bus_i.addr == ADR_SCRATCH) begin
					rd = s_r.scratch;
				end
				s_nxt.rd_data = rd;
			end
			// Writes; guarded bits keep their stored value while locked
			if (reg_bus_i.wr) begin
				if (dlab && reg_bus_i.addr == ADR_ENH) begin
					s_nxt.enhanced_feature_control = reg_bus_i.wdata;
				end else if (dlab && reg_bus_i.addr == ADR_RES1) begin
					s_nxt.resume_char_first = reg_bus_i.wdata;
				end else if (dlab && reg_bus_i.addr == ADR_RES2) begin
					s_nxt.resume_char_second = reg_bus_i.wdata;
				end else if (dlab && reg_bus_i.addr == ADR_PAU1) begin
					s_nxt.pause_char_first = reg_bus_i.wdata;
				end else if (dlab && reg_bus_i.addr == ADR_PAU2) begin
					s_nxt.pause_char_second = reg_bus_i.wdata;
				end else if (reg_bus_i.addr == ADR_LINE_CTL) begin
					s_nxt.line_control_reg = reg_bus_i.wdata;
				end else if (!dlab && reg_bus_i.addr == ADR_INT_EN) begin
					s_nxt.interrupt_enable_reg = enh ? reg_bus_i.wdata
						: (reg_bus_i.wdata & ~GUARD_INT_EN)
						| (s_r.interrupt_enable_reg & GUARD_INT_EN);
				end else if (!dlab && reg_bus_i.addr == ADR_FCTL) begin
					s_nxt.fifo_control_reg = enh ? reg_bus_i.wdata
						: (reg_bus_i.wdata & ~GUARD_FCTL)
						| (s_r.fifo_control_reg & GUARD_FCTL);
				end else if (!dlab && reg_bus_i.addr == ADR_MDM_CTL) begin
					s_nxt.modem_control_reg = enh ? reg_bus_i.wdata
						: (reg_bus_i.wdata & ~GUARD_MDM)
						| (s_r.modem_control_reg & GUARD_MDM);
				end else if (!dlab && reg_bus_i.addr == ADR_SCRATCH) begin
					s_nxt.scratch = reg_bus_i.wdata;
				end
			end
			// Receive side: special detect and flow character matching
			s_nxt.rx_store.valid = 1'b0;
			if (rx_char_i.valid) begin
				if (efc[ENH_SCD] && d == s_r.pause_char_second) begin
					s_nxt.sc_hit = 1'b1;
				end else if (efc[1:0] == 2'b10 || efc[1:0] == 2'b01) begin
					pa = efc[1] ? s_r.pause_char_first : s_r.pause_char_second;
					re = efc[1] ? s_r.resume_char_first : s_r.resume_char_second;
					if (d == pa) begin
						s_nxt.paused = 1'b1;
						cons = 1'b1;
					end else if (d == re) begin
						s_nxt.paused = 1'b0;
						cons = 1'b1;
					end
				end else if (efc[1:0] == 2'b11) begin
					// Second half must follow the first directly
					if (s_r.rx_half && d == (s_r.half_pause
						? s_r.pause_char_second : s_r.resume_char_second)) begin
						s_nxt.paused = s_r.half_pause;
						cons = 1'b1;
					end
					s_nxt.rx_half = 1'b0;
					if (!cons && d == s_r.pause_char_first) begin
						s_nxt.rx_half = 1'b1;
						s_nxt.half_pause = 1'b1;
					end else if (!cons && d == s_r.resume_char_first) begin
						s_nxt.rx_half = 1'b1;
						s_nxt.half_pause = 1'b0;
					end
				end
				if (!cons && mctl_vis[MC_ANY]) begin
					s_nxt.paused = 1'b0;
				end
				s_nxt.rx_store.valid = !cons;
				s_nxt.rx_store.data = d;
			end
			// Transmit side: send pause or resume as the FIFO crosses trigger
			case (s_r.txf)
				TF_IDLE: begin
					if (efc[3:2] != 2'b00 && want_pause != s_r.sent_pause) begin
						s_nxt.sent_pause = want_pause;
						s_nxt.txf = TF_SEND1;
						s_nxt.tx_flow.valid = 1'b1;
						if (efc[3]) begin
							s_nxt.tx_flow.data = want_pause ? s_r.pause_char_first
								: s_r.resume_char_first;
						end else begin
							s_nxt.tx_flow.data = want_pause ? s_r.pause_char_second
								: s_r.resume_char_second;
						end
					end
				end
				TF_SEND1: begin
					if (tx_flow_ready_i && efc[3:2] == 2'b11) begin
						s_nxt.txf = TF_SEND2;
						s_nxt.tx_flow.data = s_r.sent_pause ? s_r.pause_char_second
							: s_r.resume_char_second;
					end else if (tx_flow_ready_i) begin
						s_nxt.txf = TF_IDLE;
						s_nxt.tx_flow.valid = 1'b0;
					end
				end
				TF_SEND2: begin
					if (tx_flow_ready_i) begin
						s_nxt.txf = TF_IDLE;
						s_nxt.tx_flow.valid = 1'b0;
					end
				end
				default: begin
					s_nxt.txf = TF_IDLE;
					s_nxt.tx_flow.valid = 1'b0;
				end
			endcase
			// Modem deltas: a change in the reading cycle still sets
			s_nxt.mdm_delta = s_nxt.mdm_delta | mdm_chg;
			s_nxt.mdm_prev = mdm_n;
			s_nxt.prev_ok = 1'b1;
			s_nxt.line_status_reg = line_stat_i;
			// Auto request-to-send hysteresis between two trigger levels
			if (!efc[ENH_ARTS]) begin
				s_nxt.rts_stop = 1'b0;
			end else if (own_lvl >= trig_next) begin
				s_nxt.rts_stop = 1'b1;
			end else if (own_lvl < trig) begin
				s_nxt.rts_stop = 1'b0;
			end
			s_nxt.rts_n = efc[ENH_ARTS] ? s_nxt.rts_stop
				: ~s_r.modem_control_reg[MC_RTS];
			s_nxt.dtr_n = ~s_r.modem_control_reg[MC_DTR];
			s_nxt.ser_tx = ser_data_i & ~s_r.line_control_reg[LC_BRK];
			s_nxt.rx_ready_n = own_lvl == '0;
			s_nxt.tx_ready_n = tx_lvl_i[0] == DEPTH_L;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_r <= '0;
			s_r.interrupt_enable_reg <= RST_ZERO;
			s_r.fifo_control_reg <= RST_ZERO;
			s_r.line_control_reg <= RST_ZERO;
			s_r.modem_control_reg <= RST_ZERO;
			s_r.line_status_reg <= RST_LINE_STAT;
			s_r.mdm_delta <= 4'h0;
			s_r.enhanced_feature_control <= RST_ZERO;
			s_r.txf <= TF_IDLE;
			s_r.ser_tx <= 1'b1;
			s_r.rts_n <= 1'b1;
			s_r.dtr_n <= 1'b1;
			s_r.rx_ready_n <= 1'b1;
			s_r.tx_ready_n <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rd_data_o = s_r.rd_data;
	assign rx_store_o = s_r.rx_store;
	assign tx_flow_o = s_r.tx_flow;
	assign tx_enable_o = ~s_r.paused & ~(efc[ENH_ACTS] & cts_n_i);
	assign rx_trig_o = efc[ENH_ARTS] & want_pause;
	assign ser_tx_o = s_r.ser_tx;
	assign rts_n_o = s_r.rts_n;
	assign dtr_n_o = s_r.dtr_n;
	assign receive_ready_pin_n_o = s_r.rx_ready_n;
	assign transmit_ready_pin_n_o = s_r.tx_ready_n;

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_wr_enh_locked;
		ce_i && reg_bus_i.wr && !dlab && reg_bus_i.addr == ADR_ENH;
	endsequence
	sequence s_dual_first;
		ce_i && s_r.txf == TF_SEND1 && tx_flow_ready_i && efc[3:2] == 2'b11;
	endsequence

	a_enh_lock_hold: assert property (s_wr_enh_locked |=> $stable(efc))
		else $error("enhanced control changed without latch bit");
	a_guard_hidden: assert property (ce_i && reg_bus_i.rd && !dlab && !enh
		&& reg_bus_i.addr == ADR_INT_EN |=> rd_data_o[7:4] == 4'h0)
		else $error("guarded enable bits visible while locked");
	a_guard_write: assert property (ce_i && reg_bus_i.wr && !dlab && enh
		&& reg_bus_i.addr == ADR_INT_EN |=>
		s_r.interrupt_enable_reg == $past(reg_bus_i.wdata))
		else $error("enhanced write to enable register lost");
	a_rts_follow: assert property (ce_i && !efc[ENH_ARTS]
		|=> rts_n_o == ~$past(s_r.modem_control_reg[MC_RTS]))
		else $error("request pin ignores modem control");
	a_rts_stop: assert property (ce_i && efc[ENH_ARTS] && own_lvl >= trig_next
		|=> rts_n_o)
		else $error("request pin not raised at next level");
	a_rts_resume: assert property (ce_i && efc[ENH_ARTS] && own_lvl < trig
		|=> !rts_n_o)
		else $error("request pin not lowered below trigger");
	a_cts_block: assert property (efc[ENH_ACTS] && cts_n_i |-> !tx_enable_o)
		else $error("transmit allowed while clear-to-send high");
	a_special_store: assert property (ce_i && rx_char_i.valid && efc[ENH_SCD]
		&& rx_char_i.data == s_r.pause_char_second
		|=> rx_store_o.valid && s_r.sc_hit)
		else $error("special character not stored or flagged");
	a_dual_second: assert property (s_dual_first |=> tx_flow_o.valid
		&& s_r.txf == TF_SEND2 && tx_flow_o.data == (s_r.sent_pause
		? s_r.pause_char_second : s_r.resume_char_second))
		else $error("second flow character not sent");
	// Status bit and pin are built apart; they must agree on a full FIFO
	a_tx_ready_bit: assert property (ce_i |=> transmit_ready_pin_n_o == !$past(frdy[0]))
		else $error("transmit ready bit wrong");
	// A receive FIFO at its trigger cannot report itself ready
	a_rx_ready_bit: assert property (rx_trig_o |-> !frdy[4])
		else $error("receive ready bit set at trigger");
	// Matched single pause character is consumed and stops the transmitter
	a_flow_consumed: assert property (ce_i && rx_char_i.valid && !efc[ENH_SCD]
		&& efc[1:0] == 2'b10 && rx_char_i.data == s_r.pause_char_first
		|=> !rx_store_o.valid && !tx_enable_o)
		else $error("pause character stored or ignored");
endmodule

//--- dv/tb.sv
// Self-checking bench for the enhanced flow-control channel
`timescale 1ns/1ps
module tb import uef_pkg::*;;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	uef_bus_t bus = '0;
	logic [7:0] rd_data;
	uef_char_t rx_char, rx_store, tx_flow;
	logic tx_ready, tx_en, rx_trig, ser_tx, rts_n, dtr_n, rx_ready_n, tx_ready_n;
	logic [3:0][LVL_W-1:0] rx_lvl = '0;
	logic [3:0][LVL_W-1:0] tx_lvl = '0;
	logic [3:0] rx_tout = '0;
	logic [3:0][1:0] ch_trig = '0;
	logic cts_hold = 1'b0;
	logic [3:0] delay = 4'h0;
	logic cts_n, dsr_n, ri_n, cd_n;
	int errors = 0;
	int checks = 0;
	int cycles = 0;

	initial begin
		forever #4 mclk_i = ~mclk_i;
	end

	uef_core u_uef_core (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .reg_bus_i(bus),
		.rd_data_o(rd_data), .rx_char_i(rx_char), .rx_store_o(rx_store), .tx_flow_o(tx_flow),
		.tx_flow_ready_i(tx_ready), .tx_enable_o(tx_en), .rx_trig_o(rx_trig),
		.rx_lvl_i(rx_lvl), .tx_lvl_i(tx_lvl), .rx_tout_i(rx_tout), .ch_trig_i(ch_trig),
		.line_stat_i(8'h60), .cts_n_i(cts_n), .dsr_n_i(dsr_n), .ri_n_i(ri_n), .cd_n_i(cd_n),
		.ser_data_i(1'b1), .ser_tx_o(ser_tx), .rts_n_o(rts_n), .dtr_n_o(dtr_n),
		.receive_ready_pin_n_o(rx_ready_n), .transmit_ready_pin_n_o(tx_ready_n));

	uef_remote u_uef_remote (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cts_hold_i(cts_hold),
		.delay_i(delay), .tx_flow_i(tx_flow), .rx_char_o(rx_char),
		.tx_flow_ready_o(tx_ready), .cts_n_o(cts_n), .dsr_n_o(dsr_n), .ri_n_o(ri_n),
		.cd_n_o(cd_n));

	task automatic stop_test();
		if (errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			stop_test();
		end
	end

	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		bus <= {a, d, 1'b1, 1'b0};
		@(posedge mclk_i);
		bus <= '0;
	endtask

	task automatic rdc(input logic [3:0] a, input logic [7:0] e);
		@(posedge mclk_i);
		bus <= {a, 8'h00, 1'b0, 1'b1};
		@(posedge mclk_i);
		bus <= '0;
		#1;
		chk($sformatf("reg %0h", a), rd_data, e);
	endtask

	task automatic set_efr(input logic [7:0] v);
		wr(ADR_LINE_CTL, 8'h80);
		wr(ADR_ENH, v);
		wr(ADR_LINE_CTL, 8'h00);
	endtask

	task automatic set_chars(input logic [7:0] r1, r2, p1, p2);
		wr(ADR_LINE_CTL, 8'h80);
		wr(ADR_RES1, r1);
		wr(ADR_RES2, r2);
		wr(ADR_PAU1, p1);
		wr(ADR_PAU2, p2);
		wr(ADR_LINE_CTL, 8'h00);
	endtask

	// Sends one character, then judges storing and the transmit gate
	task automatic rx(input logic [7:0] c, input logic st, input logic en);
		u_uef_remote.send(c);
		#1;
		chk("store valid", {7'h00, rx_store.valid}, {7'h00, st});
		if (st)
			chk("store data", rx_store.data, c);
		chk("tx enable", {7'h00, tx_en}, {7'h00, en});
	endtask

	task automatic lvl(input logic [6:0] v);
		@(posedge mclk_i);
		rx_lvl[0] <= v;
		repeat (2) @(posedge mclk_i);
		#1;
	endtask

	task automatic t_reset();
		rdc(ADR_INT_EN, 8'h00);
		rdc(ADR_FCTL, 8'h01);
		rdc(ADR_LINE_CTL, 8'h00);
		rdc(ADR_MDM_CTL, 8'h00);
		rdc(ADR_LINE_STAT, 8'h60);
		rdc(ADR_MDM_STAT, 8'hB0);
		wr(ADR_LINE_CTL, 8'h80);
		rdc(ADR_ENH, 8'h00);
		wr(ADR_RES1, 8'hA5);
		rdc(ADR_RES1, 8'hA5);
		wr(ADR_LINE_CTL, 8'h00);
		rdc(ADR_MDM_CTL, 8'h00);
		set_efr(8'h10);
		rdc(ADR_INT_EN, 8'h00);
		rdc(ADR_MDM_CTL, 8'h00);
		set_efr(8'h00);
	endtask

	task automatic t_guard();
		wr(ADR_FCTL, 8'h30);
		wr(ADR_INT_EN, 8'hFF);
		rdc(ADR_INT_EN, 8'h0F);
		set_efr(8'h10);
		rdc(ADR_INT_EN, 8'h0F);
		wr(ADR_INT_EN, 8'hFF);
		rdc(ADR_INT_EN, 8'hFF);
		wr(ADR_MDM_CTL, 8'hE0);
		rdc(ADR_MDM_CTL, 8'hE0);
		set_efr(8'h00);
		rdc(ADR_INT_EN, 8'h0F);
		rdc(ADR_MDM_CTL, 8'h00);
		set_efr(8'h10);
		rdc(ADR_INT_EN, 8'hFF);
		rdc(ADR_MDM_CTL, 8'hE0);
	endtask

	task automatic t_rxflow();
		logic [7:0] p, r, o;
		set_chars(8'h11, 8'h21, 8'h13, 8'h23);
		for (int i = 0; i < 2; i++) begin
			p = i ? 8'h23 : 8'h13;
			r = i ? 8'h21 : 8'h11;
			o = i ? 8'h13 : 8'h23;
			set_efr(i ? 8'h01 : 8'h02);
			rx(o, 1'b1, 1'b1);
			rx(p, 1'b0, 1'b0);
			rx(p ^ 8'h01, 1'b1, 1'b0);
			rx(r, 1'b0, 1'b1);
		end
		set_efr(8'h03);
		rx(8'h55, 1'b1, 1'b1);
		rx(8'h23, 1'b1, 1'b1);
		rx(8'h13, 1'b1, 1'b1);
		rx(8'h23, 1'b0, 1'b0);
		rx(8'h11, 1'b1, 1'b0);
		rx(8'h21, 1'b0, 1'b1);
	endtask

	task automatic t_txflow();
		logic [7:0] m[3] = '{8'h08, 8'h04, 8'h0C};
		for (int i = 0; i < 3; i++) begin
			delay <= (i == 2) ? 4'h3 : 4'h0;
			set_efr(m[i]);
			for (int s = 0; s < 2; s++) begin
				lvl(s ? 7'h00 : 7'h08);
				for (int k = 0; k < 100 && u_uef_remote.got.size() < (i / 2) + 1; k++)
					@(posedge mclk_i);
				chk("flow count", 8'(u_uef_remote.got.size()), 8'((i / 2) + 1));
				chk("flow first", u_uef_remote.got[0], {4'h1 + 4'(i == 1), 4'h3 - 4'(2 * s)});
				if (i == 2)
					chk("flow second", u_uef_remote.got[1], 8'h23 - 8'(2 * s));
				u_uef_remote.got.delete();
			end
		end
		set_efr(8'h00);
	endtask

	task automatic t_special();
		set_chars(8'h11, 8'h21, 8'h13, 8'h55);
		set_efr(8'h30);
		rx(8'h54, 1'b1, 1'b1);
		rdc(ADR_FCTL, 8'h01);
		rx(8'h55, 1'b1, 1'b1);
		rdc(ADR_FCTL, 8'h10);
		rdc(ADR_FCTL, 8'h01);
		set_efr(8'h00);
	endtask

	task automatic t_rts();
		wr(ADR_MDM_CTL, 8'h02);
		lvl(7'h40);
		chk("rts", {7'h00, rts_n}, 8'h00);
		lvl(7'h00);
		set_efr(8'h40);
		lvl(7'h08);
		chk("trigger", {7'h00, rx_trig}, 8'h01);
		chk("rts", {7'h00, rts_n}, 8'h00);
		lvl(7'h10);
		chk("rts", {7'h00, rts_n}, 8'h01);
		lvl(7'h08);
		chk("rts", {7'h00, rts_n}, 8'h01);
		lvl(7'h07);
		chk("rts", {7'h00, rts_n}, 8'h00);
		wr(ADR_FCTL, 8'hC0);
		lvl(7'h3C);
		chk("rts", {7'h00, rts_n}, 8'h00);
		lvl(7'h40);
		chk("rts", {7'h00, rts_n}, 8'h01);
		lvl(7'h3B);
		chk("rts", {7'h00, rts_n}, 8'h00);
		wr(ADR_FCTL, 8'h00);
		set_efr(8'h00);
		wr(ADR_MDM_CTL, 8'h00);
	endtask

	task automatic t_cts();
		for (int i = 0; i < 2; i++) begin
			set_efr(i ? 8'h80 : 8'h00);
			@(posedge mclk_i);
			cts_hold <= 1'b1;
			repeat (2) @(posedge mclk_i);
			#1;
			chk("tx enable", {7'h00, tx_en}, {7'h00, ~i[0]});
			cts_hold <= 1'b0;
			repeat (2) @(posedge mclk_i);
			#1;
			chk("tx enable", {7'h00, tx_en}, 8'h01);
		end
		set_efr(8'h00);
	endtask

	task automatic t_ready();
		@(posedge mclk_i);
		rx_lvl <= {7'h00, 7'h00, 7'h14, 7'h07};
		tx_lvl <= {7'h40, 7'h00, 7'h3F, 7'h40};
		rx_tout <= 4'b0100;
		ch_trig <= {2'b00, 2'b00, 2'b01, 2'b00};
		rdc(ADR_FIFO_RDY, 8'h96);
		chk("rx ready pin", {7'h00, rx_ready_n}, 8'h00);
		chk("tx ready pin", {7'h00, tx_ready_n}, 8'h01);
	endtask

	task automatic pins_in_reset();
		#1;
		chk("ser tx", {7'h00, ser_tx}, 8'h01);
		chk("rts", {7'h00, rts_n}, 8'h01);
		chk("dtr", {7'h00, dtr_n}, 8'h01);
		chk("rx ready pin", {7'h00, rx_ready_n}, 8'h01);
		chk("tx ready pin", {7'h00, tx_ready_n}, 8'h00);
		chk("line status", u_uef_core.s_r.line_status_reg, RST_LINE_STAT);
	endtask

	initial begin
		repeat (8) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		pins_in_reset();
		t_reset();
		t_guard();
		@(posedge mclk_i);
		rst_n_i <= 1'b0;
		repeat (8) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		pins_in_reset();
		t_reset();
		t_rxflow();
		t_txflow();
		t_special();
		t_rts();
		t_cts();
		t_ready();
		stop_test();
	end
endmodule

//--- dv/uef_remote.sv
// Remote serial peer: sends characters, takes flow characters, drives modem lines
`timescale 1ns/1ps
module uef_remote import uef_pkg::*; (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Control from the bench
	input wire logic cts_hold_i,
	input wire logic [3:0] delay_i,
	// Design side
	input wire uef_char_t tx_flow_i,
	output uef_char_t rx_char_o,
	output logic tx_flow_ready_o,
	output logic cts_n_o,
	output logic dsr_n_o,
	output logic ri_n_o,
	output logic cd_n_o
);
	logic [7:0] got[$];
	logic [3:0] cnt;
	// Peer stops our transmitter by holding its line high
	assign cts_n_o = cts_hold_i;
	assign dsr_n_o = 1'b0;
	assign ri_n_o = 1'b1;
	assign cd_n_o = 1'b0;
	initial rx_char_o = '0;
	task automatic send(input logic [7:0] c);
		@(posedge mclk_i);
		rx_char_o <= {1'b1, c};
		@(posedge mclk_i);
		rx_char_o <= {1'b0, ~c};
	endtask
	// Takes each flow character after a programmable stall
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_flow_ready_o <= 1'b0;
			cnt <= 4'h0;
		end else if (tx_flow_i.valid && !tx_flow_ready_o) begin
			if (cnt >= delay_i) begin
				tx_flow_ready_o <= 1'b1;
				cnt <= 4'h0;
			end else begin
				cnt <= cnt + 4'h1;
			end
		end else begin
			if (tx_flow_i.valid && tx_flow_ready_o)
				got.push_back(tx_flow_i.data);
			tx_flow_ready_o <= 1'b0;
		end
	end
endmodule

//--- include/uef_pkg.sv
// Constants and types for the enhanced flow-control UART channel
package uef_pkg;
	// Register indices on the plain register port
	localparam logic [3:0] ADR_INT_EN = 4'h1;
	localparam logic [3:0] ADR_FCTL = 4'h2;
	localparam logic [3:0] ADR_LINE_CTL = 4'h3;
	localparam logic [3:0] ADR_MDM_CTL = 4'h4;
	localparam logic [3:0] ADR_LINE_STAT = 4'h5;
	localparam logic [3:0] ADR_MDM_STAT = 4'h6;
	localparam logic [3:0] ADR_SCRATCH = 4'h7;
	localparam logic [3:0] ADR_FIFO_RDY = 4'h8;
	// Shown only while the divisor-latch bit is set
	localparam logic [3:0] ADR_ENH = 4'h2;
	localparam logic [3:0] ADR_RES1 = 4'h4;
	localparam logic [3:0] ADR_RES2 = 4'h5;
	localparam logic [3:0] ADR_PAU1 = 4'h6;
	localparam logic [3:0] ADR_PAU2 = 4'h7;
	// Field positions
	localparam int ENH_ON = 4;
	localparam int ENH_SCD = 5;
	localparam int ENH_ARTS = 6;
	localparam int ENH_ACTS = 7;
	localparam int LC_DLAB = 7;
	localparam int LC_BRK = 6;
	localparam int MC_DTR = 0;
	localparam int MC_RTS = 1;
	localparam int MC_LOOP = 4;
	localparam int MC_ANY = 5;
	// Bits latched by the enhanced function bit
	localparam logic [7:0] GUARD_INT_EN = 8'hF0;
	localparam logic [7:0] GUARD_SRC = 8'h30;
	localparam logic [7:0] GUARD_FCTL = 8'h30;
	localparam logic [7:0] GUARD_MDM = 8'hE0;
	// Reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_LINE_STAT = 8'h60;
	// Receive trigger levels
	localparam int LVL_W = 7;
	localparam logic [LVL_W-1:0] TRIG_0 = 7'h08;
	localparam logic [LVL_W-1:0] TRIG_1 = 7'h10;
	localparam logic [LVL_W-1:0] TRIG_2 = 7'h38;
	localparam logic [LVL_W-1:0] TRIG_3 = 7'h3C;

	function automatic logic [LVL_W-1:0] trig_lvl(input logic [1:0] sel);
		case (sel)
			2'b00: return TRIG_0;
			2'b01: return TRIG_1;
			2'b10: return TRIG_2;
			default: return TRIG_3;
		endcase
	endfunction

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} uef_bus_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} uef_char_t;

	typedef enum logic [1:0] {TF_IDLE, TF_SEND1, TF_SEND2} uef_txf_t;

	typedef struct packed {
		logic [7:0] interrupt_enable_reg;
		logic [7:0] fifo_control_reg;
		logic [7:0] line_control_reg;
		logic [7:0] modem_control_reg;
		logic [7:0] line_status_reg;
		logic [7:0] scratch;
		logic [7:0] enhanced_feature_control;
		logic [7:0] resume_char_first;
		logic [7:0] resume_char_second;
		logic [7:0] pause_char_first;
		logic [7:0] pause_char_second;
		logic [3:0] mdm_delta;
		logic [3:0] mdm_prev;
		logic prev_ok;
		logic sc_hit;
		logic rts_stop;
		logic paused;
		logic rx_half;
		logic half_pause;
		logic sent_pause;
		uef_txf_t txf;
		uef_char_t tx_flow;
		uef_char_t rx_store;
		logic [7:0] rd_data;
		logic ser_tx;
		logic rts_n;
		logic dtr_n;
		logic rx_ready_n;
		logic tx_ready_n;
	} uef_state_t;
endpackage
